/* design/fss_status_id.sv */
`timescale 1ns/1ps
module fss_status_id (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic cs_b,
  input wire logic si,
  output logic so,
  output logic so_oe_b,
  input wire logic op_busy,
  input wire logic [15:0] nv_status,
  output logic write_latch,
  output fss_pkg::fss_cfg_t cfg,
  output logic nv_wr_stb,
  output logic [15:0] nv_wr_data
);

  // ----------------------------------------------------------------
  // Link side: bit capture on rising sck
  // ----------------------------------------------------------------
  logic fresh;
  logic [fss_pkg::CNT_W-1:0] bit_cnt;
  logic [fss_pkg::CNT_W-1:0] next_bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] next_shift_in;
  logic [7:0] cmd_l;
  logic [7:0] next_cmd_l;
  logic [7:0] data1_l;
  logic [7:0] next_data1_l;
  logic [7:0] data2_l;
  logic [7:0] next_data2_l;

  // Fresh is preset while select is high so the first edge starts a frame
  always_ff @(posedge sck or posedge cs_b or negedge rst_b) begin
    if (!rst_b) begin
      fresh <= 1'b1;
    end else if (cs_b) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  always_comb begin
    next_shift_in = {shift_in[6:0], si};
    if (fresh) begin
      next_bit_cnt = fss_pkg::CNT_W'(1);
    end else if (bit_cnt == fss_pkg::CNT_MAX) begin
      next_bit_cnt = bit_cnt;
    end else begin
      next_bit_cnt = bit_cnt + fss_pkg::CNT_W'(1);
    end
    next_cmd_l = cmd_l;
    next_data1_l = data1_l;
    next_data2_l = data2_l;
    if (next_bit_cnt == fss_pkg::CNT_OPCODE) begin
      next_cmd_l = next_shift_in;
    end
    if (next_bit_cnt == fss_pkg::CNT_ONE_BYTE) begin
      next_data1_l = next_shift_in;
    end
    if (next_bit_cnt == fss_pkg::CNT_TWO_BYTES) begin
      next_data2_l = next_shift_in;
    end
  end

  // Captured frame stays frozen after select rises, since sck then stands still
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt <= '0;
      shift_in <= '0;
      cmd_l <= '0;
      data1_l <= '0;
      data2_l <= '0;
    end else begin
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      cmd_l <= next_cmd_l;
      data1_l <= next_data1_l;
      data2_l <= next_data2_l;
    end
  end

  // ----------------------------------------------------------------
  // Link side: output on falling sck
  // ----------------------------------------------------------------
  logic [15:0] status_link;
  logic [15:0] status_sys;
  logic next_so;
  logic next_so_oe_b;

  fss_sync2 #(
    .WIDTH(16),
    .INIT(16'h0000)
  ) u_status_sync (
    .clk(sck),
    .rst_b(rst_b),
    .d(status_sys),
    .q(status_link)
  );

  // Byte to send for a given reply index
  function automatic logic [7:0] reply_byte(input logic [7:0] op, input logic [4:0] idx,
                                            input logic [15:0] st);
    logic [1:0] pos3;
    pos3 = 2'(idx % 5'h03);
    reply_byte = 8'h00;
    case (op)
      fss_pkg::OP_READ_STATUS_LOW: reply_byte = st[7:0];
      fss_pkg::OP_READ_STATUS_HIGH: reply_byte = st[15:8];
      fss_pkg::OP_READ_ID: begin
        case (pos3)
          2'h0: reply_byte = fss_pkg::ID_MAKER;
          2'h1: reply_byte = {fss_pkg::ID_FAMILY, fss_pkg::ID_DENSITY};
          default: reply_byte = {fss_pkg::ID_SUB, fss_pkg::ID_VERSION};
        endcase
      end
      fss_pkg::OP_READ_ID_LEGACY: begin
        reply_byte = idx[0] ? fss_pkg::ID_LEGACY : fss_pkg::ID_MAKER;
      end
      fss_pkg::OP_WAKE_READ_ID: reply_byte = fss_pkg::ID_LEGACY;
      default: reply_byte = 8'h00;
    endcase
  endfunction

  always_comb begin
    logic [fss_pkg::CNT_W-1:0] start;
    logic [fss_pkg::CNT_W-1:0] k;
    logic [7:0] rb;
    logic drive;
    start = fss_pkg::CNT_OPCODE;
    drive = 1'b0;
    case (cmd_l)
      fss_pkg::OP_READ_STATUS_LOW, fss_pkg::OP_READ_STATUS_HIGH, fss_pkg::OP_READ_ID: begin
        drive = 1'b1;
      end
      fss_pkg::OP_READ_ID_LEGACY, fss_pkg::OP_WAKE_READ_ID: begin
        drive = 1'b1;
        start = fss_pkg::CNT_DUMMY_END;
      end
      default: drive = 1'b0;
    endcase
    k = bit_cnt - start;
    rb = reply_byte(cmd_l, k[7:3], status_link);
    if (!fresh && drive && bit_cnt >= start && bit_cnt != fss_pkg::CNT_MAX) begin
      next_so = rb[3'h7 - k[2:0]];
      next_so_oe_b = 1'b0;
    end else begin
      next_so = 1'b0;
      next_so_oe_b = 1'b1;
    end
  end

  // Select release floats the output at once, mid-byte or not
  always_ff @(negedge sck or posedge cs_b or negedge rst_b) begin
    if (!rst_b) begin
      so <= 1'b0;
      so_oe_b <= 1'b1;
    end else if (cs_b) begin
      so <= 1'b0;
      so_oe_b <= 1'b1;
    end else begin
      so <= next_so;
      so_oe_b <= next_so_oe_b;
    end
  end

  // ----------------------------------------------------------------
  // System side: frame end detection
  // ----------------------------------------------------------------
  logic cs_sync;
  logic cs_prev;
  logic frame_end;

  fss_sync2 #(
    .WIDTH(1),
    .INIT(1'b1)
  ) u_cs_sync (
    .clk(clk_sys),
    .rst_b(rst_b),
    .d(cs_b),
    .q(cs_sync)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= cs_sync;
    end
  end

  assign frame_end = cs_sync && !cs_prev;

  // ----------------------------------------------------------------
  // System side: command execution and volatile status copy
  // ----------------------------------------------------------------
  logic loaded;
  logic next_loaded;
  logic vol_arm;
  logic next_vol_arm;
  logic next_write_latch;
  fss_pkg::fss_cfg_t next_cfg;
  logic next_nv_wr_stb;
  logic [15:0] next_nv_wr_data;
  logic [15:0] next_status_sys;

  function automatic fss_pkg::fss_cfg_t unpack_cfg(input logic [7:0] lo, input logic [7:0] hi);
    fss_pkg::fss_cfg_t c;
    c.status_guard_low = lo[fss_pkg::LOW_GUARD];
    c.granularity_select = lo[fss_pkg::LOW_GRAN];
    c.top_bottom_select = lo[fss_pkg::LOW_TB];
    {c.prot_size_hi, c.prot_size_mid, c.prot_size_lo} =
      lo[fss_pkg::LOW_SIZE_HI:fss_pkg::LOW_SIZE_LO];
    c.prot_invert = hi[fss_pkg::HIGH_INVERT];
    {c.page_lock_c, c.page_lock_b, c.page_lock_a} =
      hi[fss_pkg::HIGH_LOCK_C:fss_pkg::HIGH_LOCK_A];
    c.quad_io_on = hi[fss_pkg::HIGH_QUAD];
    c.status_guard_high = hi[fss_pkg::HIGH_GUARD];
    unpack_cfg = c;
  endfunction

  function automatic logic [15:0] pack_status(input fss_pkg::fss_cfg_t c, input logic wl,
                                              input logic busy);
    pack_status = {1'b0, c.prot_invert, c.page_lock_c, c.page_lock_b, c.page_lock_a,
                   1'b0, c.quad_io_on, c.status_guard_high,
                   c.status_guard_low, c.granularity_select, c.top_bottom_select,
                   c.prot_size_hi, c.prot_size_mid, c.prot_size_lo, wl, busy};
  endfunction

  always_comb begin
    logic complete;
    logic [7:0] hi_byte;
    logic [15:0] cur;
    next_loaded = 1'b1;
    next_vol_arm = vol_arm;
    next_write_latch = write_latch;
    next_cfg = cfg;
    next_nv_wr_stb = 1'b0;
    next_nv_wr_data = nv_wr_data;
    cur = pack_status(cfg, 1'b0, 1'b0);
    complete = (bit_cnt == fss_pkg::CNT_ONE_BYTE) || (bit_cnt == fss_pkg::CNT_TWO_BYTES);
    hi_byte = (bit_cnt == fss_pkg::CNT_TWO_BYTES) ?
              (data2_l & fss_pkg::HIGH_WRITE_MASK) : cur[15:8];
    if (!loaded) begin
      next_cfg = unpack_cfg(nv_status[7:0], nv_status[15:8] & fss_pkg::HIGH_WRITE_MASK);
    end else if (frame_end && bit_cnt == fss_pkg::CNT_OPCODE
                 && (bit_cnt & fss_pkg::CNT_W'(fss_pkg::BYTE_ALIGN_MASK)) == '0) begin
      case (cmd_l)
        fss_pkg::OP_WRITE_ENABLE: next_write_latch = 1'b1;
        fss_pkg::OP_WRITE_DISABLE: next_write_latch = 1'b0;
        fss_pkg::OP_VOL_ENABLE: next_vol_arm = 1'b1;
        fss_pkg::OP_WRITE_STATUS: begin
          next_write_latch = 1'b0;
          next_vol_arm = 1'b0;
        end
        default: next_vol_arm = vol_arm;
      endcase
    end else if (frame_end && bit_cnt > fss_pkg::CNT_OPCODE
                 && cmd_l == fss_pkg::OP_WRITE_STATUS) begin
      next_write_latch = 1'b0;
      next_vol_arm = 1'b0;
      if (complete && (write_latch || vol_arm)) begin
        next_cfg = unpack_cfg(data1_l, hi_byte);
        if (!vol_arm) begin
          next_nv_wr_stb = 1'b1;
          next_nv_wr_data = {hi_byte, data1_l[fss_pkg::LOW_GUARD:fss_pkg::LOW_SIZE_LO],
                             2'h0};
        end
      end
    end
    next_status_sys = pack_status(next_cfg, next_write_latch, op_busy);
  end

  // Latch and arm start clear at reset; copy is loaded one edge after release
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      loaded <= 1'b0;
      vol_arm <= 1'b0;
      write_latch <= 1'b0;
      cfg <= fss_pkg::CFG_RESET;
      nv_wr_stb <= 1'b0;
      nv_wr_data <= '0;
    end else begin
      loaded <= next_loaded;
      vol_arm <= next_vol_arm;
      write_latch <= next_write_latch;
      cfg <= next_cfg;
      nv_wr_stb <= next_nv_wr_stb;
      nv_wr_data <= next_nv_wr_data;
    end
  end

  // Status word toward the link; busy mirrors the program/erase engine
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      status_sys <= '0;
    end else begin
      status_sys <= next_status_sys;
    end
  end

endmodule

/* design/fss_pkg.sv */
package fss_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_VOL_ENABLE = 8'h50;
  localparam logic [7:0] OP_READ_STATUS_LOW = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_HIGH = 8'h35;
  localparam logic [7:0] OP_READ_ID = 8'h9F;
  localparam logic [7:0] OP_READ_ID_LEGACY = 8'h90;
  localparam logic [7:0] OP_WAKE_READ_ID = 8'hAB;

  // ----------------------------------------------------------------
  // Frame bit counts
  // ----------------------------------------------------------------
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_OPCODE = 8'h08;
  localparam logic [CNT_W-1:0] CNT_ONE_BYTE = 8'h10;
  localparam logic [CNT_W-1:0] CNT_TWO_BYTES = 8'h18;
  localparam logic [CNT_W-1:0] CNT_DUMMY_END = 8'h20;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [2:0] BYTE_ALIGN_MASK = 3'h7;

  // ----------------------------------------------------------------
  // Status byte layouts
  // ----------------------------------------------------------------
  localparam int LOW_GUARD = 7;
  localparam int LOW_GRAN = 6;
  localparam int LOW_TB = 5;
  localparam int LOW_SIZE_HI = 4;
  localparam int LOW_SIZE_LO = 2;
  localparam int HIGH_INVERT = 6;
  localparam int HIGH_LOCK_C = 5;
  localparam int HIGH_LOCK_A = 3;
  localparam int HIGH_QUAD = 1;
  localparam int HIGH_GUARD = 0;
  localparam logic [7:0] HIGH_WRITE_MASK = 8'h7B;

  // Volatile copy fields, one struct for the whole writable set
  typedef struct packed {
    logic prot_invert;
    logic page_lock_c;
    logic page_lock_b;
    logic page_lock_a;
    logic quad_io_on;
    logic status_guard_high;
    logic status_guard_low;
    logic granularity_select;
    logic top_bottom_select;
    logic prot_size_hi;
    logic prot_size_mid;
    logic prot_size_lo;
  } fss_cfg_t;

  localparam fss_cfg_t CFG_RESET = '0;

  // ----------------------------------------------------------------
  // Identification values (arbitrary neutral values)
  // ----------------------------------------------------------------
  localparam logic [7:0] ID_MAKER = 8'hA5;
  localparam logic [2:0] ID_FAMILY = 3'h2;
  localparam logic [4:0] ID_DENSITY = 5'h0B;
  localparam logic [2:0] ID_SUB = 3'h1;
  localparam logic [4:0] ID_VERSION = 5'h03;
  localparam logic [7:0] ID_LEGACY = 8'h3C;

endpackage

/* design/fss_sync2.sv */
`timescale 1ns/1ps
module fss_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= INIT;
      q <= INIT;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule

/* bench/fss_status_id_checker.sv */
`timescale 1ns/1ps
module fss_status_id_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic so,
  input wire logic so_oe_b,
  input wire logic write_latch,
  input wire fss_pkg::fss_cfg_t cfg,
  input wire logic nv_wr_stb,
  input wire logic [15:0] nv_wr_data
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_oe_sel; !so_oe_b |-> !cs_b; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("so driven while deselected");
  property p_so_idle; so_oe_b |-> !so; endproperty
  a_so_idle: assert property (p_so_idle) else $error("so not low while idle");
  property p_stb_pulse; nv_wr_stb |=> !nv_wr_stb; endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("write strobe too long");
  property p_stb_mask; nv_wr_stb |-> (nv_wr_data & 16'h8403) == 16'h0000; endproperty
  a_stb_mask: assert property (p_stb_mask) else $error("reserved bits written");
  property p_stb_cfg;
    nv_wr_stb |-> ##[0:1] cfg == {nv_wr_data[14:11], nv_wr_data[9:2]};
  endproperty
  a_stb_cfg: assert property (p_stb_cfg) else $error("cfg differs from written");
  property p_stb_clr; nv_wr_stb |-> ##[0:1] !write_latch; endproperty
  a_stb_clr: assert property (p_stb_clr) else $error("latch kept after write");
  property p_cfg_frame; $changed(cfg) |-> cs_b; endproperty
  a_cfg_frame: assert property (p_cfg_frame) else $error("cfg changed in frame");
  property p_latch_frame; $changed(write_latch) |-> cs_b; endproperty
  a_latch_frame: assert property (p_latch_frame) else $error("latch changed in frame");

  c_stb: cover property (nv_wr_stb);
  c_oe: cover property ($fell(so_oe_b));
  c_latch: cover property ($rose(write_latch));
endmodule

bind fss_status_id fss_status_id_checker chk_u (.clk_sys, .rst_b, .cs_b, .so, .so_oe_b,
  .write_latch, .cfg, .nv_wr_stb, .nv_wr_data);

/* bench/fss_host_model.sv */
`timescale 1ns/1ps
module fss_host_model (
  output logic sck,
  output logic cs_b,
  output logic si,
  input wire logic so
);
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
  end

  // Mode 0 frame, MSB first, clock still outside frames
  task automatic frame(input int nbits, input logic [63:0] mosi, output logic [63:0] miso);
    miso = '0;
    #3.3;
    cs_b = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      si = mosi[i];
      #15 sck = 1'b1;
      miso = {miso[62:0], so};
      #15 sck = 1'b0;
    end
    #15 cs_b = 1'b1;
    si = ~si;
    #200;
  endtask
endmodule

/* bench/fss_status_id_bench.sv */
`timescale 1ns/1ps
module fss_status_id_bench;
  logic clk_sys, rst_b, sck, cs_b, si, so, so_line, so_oe_b, op_busy, write_latch, nv_wr_stb;
  logic [15:0] nv_status, nv_wr_data, stb_data, st;
  logic [63:0] rx;
  logic [31:0] id_exp [3];
  logic [7:0] id_op [3];
  int id_nd [3] = '{0, 24, 24};
  fss_pkg::fss_cfg_t cfg;
  int n_fail = 0;
  int checks = 0;
  int n_stb = 0;

  fss_status_id dut_u (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .sck(sck),
    .cs_b(cs_b),
    .si(si),
    .so(so),
    .so_oe_b(so_oe_b),
    .op_busy(op_busy),
    .nv_status(nv_status),
    .write_latch(write_latch),
    .cfg(cfg),
    .nv_wr_stb(nv_wr_stb),
    .nv_wr_data(nv_wr_data)
  );
  // Released line shows the inverse so a missing drive cannot pass as data
  assign so_line = so_oe_b ? ~so : so;
  fss_host_model host_u (.sck(sck), .cs_b(cs_b), .si(si), .so(so_line));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(negedge clk_sys) begin
    if (nv_wr_stb === 1'b1) begin
      n_stb++;
      stb_data = nv_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic fss_pkg::fss_cfg_t to_cfg(input logic [15:0] s);
    return {s[14:11], s[9:2]};
  endfunction

  task automatic cmd(input logic [7:0] op);
    host_u.frame(8, {56'h0, op}, rx);
  endtask

  task automatic wr(input int n, input logic [15:0] d);
    host_u.frame(8 + n, {40'h0, fss_pkg::OP_WRITE_STATUS, d} >> (16 - n), rx);
  endtask

  task automatic rd(input logic [7:0] op, input int nd);
    host_u.frame(40 + nd, {56'h0, op} << (32 + nd), rx);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #150000;
    n_fail++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    rst_b = 1'b0;
    op_busy = 1'b0;
    nv_status = 16'h6AB7;
    st = 16'h6AB7 & 16'h7BFC;
    id_op = '{fss_pkg::OP_READ_ID, fss_pkg::OP_READ_ID_LEGACY, fss_pkg::OP_WAKE_READ_ID};
    id_exp[0] = {fss_pkg::ID_MAKER, fss_pkg::ID_FAMILY, fss_pkg::ID_DENSITY,
      fss_pkg::ID_SUB, fss_pkg::ID_VERSION, fss_pkg::ID_MAKER};
    id_exp[1] = {2{fss_pkg::ID_MAKER, fss_pkg::ID_LEGACY}};
    id_exp[2] = {4{fss_pkg::ID_LEGACY}};
    repeat (20) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (10) @(negedge clk_sys);
    nv_status = 16'h0000;
    chk(cfg, to_cfg(st));
    chk(write_latch, 0);
    op_busy = 1'b1;
    rd(fss_pkg::OP_READ_STATUS_LOW, 0);
    chk(rx[31:0], {4{st[7:2], 2'b01}});
    @(negedge clk_sys);
    op_busy = 1'b0;
    rd(fss_pkg::OP_READ_STATUS_LOW, 0);
    chk(rx[31:0], {4{st[7:2], 2'b00}});
    rd(fss_pkg::OP_READ_STATUS_HIGH, 0);
    chk(rx[31:0], {4{st[15:8]}});
    wr(16, 16'h0000);
    chk({cfg, n_stb[3:0]}, {to_cfg(st), 4'h0});
    cmd(fss_pkg::OP_WRITE_ENABLE);
    chk(write_latch, 1);
    wr(8, 16'h0300);
    st[7:0] = 8'h00;
    chk({cfg, write_latch, n_stb[3:0], stb_data[7:0]}, {to_cfg(st), 13'h0100});
    cmd(fss_pkg::OP_WRITE_ENABLE);
    wr(16, 16'hFFFF);
    st = 16'h7BFC;
    chk({cfg, n_stb[3:0], stb_data}, {to_cfg(st), 4'h2, st});
    rd(fss_pkg::OP_READ_STATUS_HIGH, 0);
    chk(rx[31:0], {4{8'h7B}});
    for (int n = 4; n <= 12; n += 8) begin
      cmd(fss_pkg::OP_WRITE_ENABLE);
      chk(write_latch, 1);
      wr(n, 16'h0000);
      chk({cfg, write_latch, n_stb[3:0]}, {to_cfg(st), 5'h02});
    end
    cmd(fss_pkg::OP_VOL_ENABLE);
    chk(write_latch, 0);
    wr(16, 16'h2A54);
    st = {8'h54 & 8'h7B, 8'h2A & 8'hFC};
    chk({cfg, n_stb[3:0]}, {to_cfg(st), 4'h2});
    rd(fss_pkg::OP_READ_STATUS_LOW, 0);
    chk(rx[31:0], {4{st[7:2], 2'b00}});
    wr(16, 16'h0000);
    chk(cfg, to_cfg(st));
    for (int k = 0; k < 3; k++) begin
      rd(id_op[k], id_nd[k]);
      chk(rx[31:0], id_exp[k]);
    end
    host_u.frame(12, {52'h0, fss_pkg::OP_READ_ID, 4'h0}, rx);
    chk({so_oe_b, so, rx[3:0]}, {2'b10, fss_pkg::ID_MAKER[7:4]});
    cmd(fss_pkg::OP_WRITE_ENABLE);
    @(negedge clk_sys);
    nv_status = 16'h0183;
    rst_b = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (10) @(negedge clk_sys);
    st = 16'h0183 & 16'h7BFC;
    chk({cfg, write_latch}, {to_cfg(st), 1'b0});
    rd(fss_pkg::OP_READ_STATUS_LOW, 0);
    chk(rx[31:0], {4{st[7:2], 2'b00}});
    end_of_test();
  end
endmodule
